//--- inc/cdpc_consts.svh
`ifndef CDPC_CONSTS_SVH
`define CDPC_CONSTS_SVH
// Overview of operation
// - loopback bit in control-port mode routes ADC output words into the DAC path
// - DAC format field is ignored during loopback; stored value applies once loopback clears
// - serial audio output keeps carrying ADC words in the ADC format during loopback
// - dither bit adds half an LSB below the top 16 bits of each ADC word whose per-channel noise bit is set
// - dither works in every output format and in master and slave clocking
// - auto-silence mutes a channel after 8192 consecutive all-zero or all-one samples
// - one non-static sample releases the channel's auto-silence at once
// - detection and muting per channel, or jointly when linked-channel mute is set
// - during auto-silence the channel's external mute output is asserted
// - silence transitions use the same soft-ramp and zero-crossing settings as volume
// - auto-silence enable resets to set
// - high-pass filter continuously estimates and subtracts the DC offset
// - each channel's high-pass filter has its own control bit
// - disabling a channel freezes its offset estimate, which is still subtracted
// - roll-off select picks fast or slow interpolation filter, fast after reset
// - three de-emphasis choices, for 32, 44.1 and 48 kHz
// - de-emphasis applies only in single speed
// - speed bits select 128x, 64x or 32x oversampling
// - mute outputs asserted in power-up, reset, muting, power-down and bad clock ratio
// - external mute outputs are active low

// ****************************************
// widths and register indices (byte address = 4 x index)
// ****************************************
`define CDPC_WORD_W 24
`define CDPC_IDX_MODE1 8'h01
`define CDPC_IDX_DAC 8'h02
`define CDPC_IDX_MIX 8'h03
`define CDPC_IDX_VOLA 8'h04
`define CDPC_IDX_VOLB 8'h05
`define CDPC_IDX_ADC 8'h06
`define CDPC_IDX_MODE2 8'h07
`define CDPC_IDX_STAT 8'h08

// ****************************************
// reset values
// ****************************************
`define CDPC_RST_MODE1 8'h00
`define CDPC_RST_DAC 8'h80
`define CDPC_RST_MIX 8'h29
`define CDPC_RST_VOL 8'h00
`define CDPC_RST_ADC 8'h00
`define CDPC_RST_MODE2 8'h00

// ****************************************
// field positions
// ****************************************
`define CDPC_SPEED_HI 7
`define CDPC_SPEED_LO 6
`define CDPC_DACFMT_MSB 2
`define CDPC_AUTOSIL 7
`define CDPC_ROLLOFF 6
`define CDPC_DEEMPH_MSB 5
`define CDPC_DEEMPH_LSB 4
`define CDPC_SOFT 5
`define CDPC_ZEROX 4
`define CDPC_VOLMUTE 7
`define CDPC_DITHER 5
`define CDPC_ADCFMT 4
`define CDPC_ADCMUTE_A 3
`define CDPC_ADCMUTE_B 2
`define CDPC_HPFRZ_A 1
`define CDPC_HPFRZ_B 0
`define CDPC_LOOP 4
`define CDPC_LINK 3
`define CDPC_CPEN 1
`define CDPC_PDN 0

// ****************************************
// timing and ratios
// ****************************************
`define CDPC_SILENCE_COUNT 8192
`define CDPC_CLK_PERIOD_NS 10
`define CDPC_PWRUP_NS 85000
`define CDPC_HPF_SHIFT 10
`define CDPC_OSR_SINGLE 8'h80
`define CDPC_OSR_DOUBLE 8'h40
`define CDPC_OSR_QUAD 8'h20
`endif

//--- inc/cdpc_pkg.sv
`include "cdpc_consts.svh"
package cdpc_pkg;
    // two channels of one sample; ch[0] is channel A
    typedef struct packed {
        logic [1:0][`CDPC_WORD_W-1:0] ch;
    } cdpc_stereo_t;

    typedef enum logic [1:0] {
        SPEED_SINGLE = 2'b00,
        SPEED_DOUBLE = 2'b01,
        SPEED_QUAD = 2'b10,
        SPEED_QUAD_ALT = 2'b11
    } cdpc_speed_t;

    typedef enum logic [1:0] {
        PWR_DOWN = 2'b00,
        PWR_RAMP = 2'b01,
        PWR_RUN = 2'b10
    } cdpc_pwr_t;

    // settings handed to the DAC datapath
    typedef struct packed {
        logic [2:0] dac_format;
        logic rolloff_slow;
        logic [1:0] deemphasis;
        logic [7:0] oversample;
        logic soft_ramp;
        logic zero_crossing_gate;
        logic [1:0] silence_req;
    } cdpc_dac_cfg_t;
endpackage

//--- rtl/cdpc_silence_det.sv
`timescale 1ns/1ns
module cdpc_silence_det #(
    parameter int W = 24,
    parameter int LIMIT = 8192,
    parameter int CW = $clog2(LIMIT + 1)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe,
    input wire logic [W-1:0] sample,
    output logic detected,
    output logic [CW-1:0] count
);
    logic [CW-1:0] count_reg;
    logic static_smp;
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    // all zeros or all ones both count as static
    assign static_smp = (sample == '0) || (sample == '1);
    assign count = count_reg;
    assign detected = (count_reg == LIM);

    // saturating run counter of static samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (strobe) begin
            if (!static_smp) begin
                count_reg <= '0;
            end else if (count_reg != LIM) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    property p_clear_on_live;
        @(posedge clk) disable iff (!rst_n) strobe && !static_smp |=> count_reg == '0 && !detected;
    endproperty
    a_clear_on_live: assert property (p_clear_on_live) else $error("counter not cleared by live sample");

    property p_hold_limit;
        @(posedge clk) disable iff (!rst_n) detected && !(strobe && !static_smp) |=> detected;
    endproperty
    a_hold_limit: assert property (p_hold_limit) else $error("counter left limit without live sample");

    property p_step;
        @(posedge clk) disable iff (!rst_n)
            strobe && static_smp && !detected |=> count_reg == $past(count_reg) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("static sample not counted");
endmodule // cdpc_silence_det

//--- rtl/cdpc_dc_block.sv
`timescale 1ns/1ns
module cdpc_dc_block #(
    parameter int W = 24,
    parameter int SH = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe,
    input wire logic freeze,
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    localparam int AW = W + SH + 1;
    logic signed [AW-1:0] acc_reg;
    logic signed [W-1:0] ofs;
    logic signed [W:0] diff;

    // offset estimate is the accumulator scaled back down
    assign ofs = W'(acc_reg >>> SH);
    assign diff = (W+1)'(x) - (W+1)'(ofs);

    // subtract always, also while frozen; saturate instead of wrapping
    always_comb begin
        if (diff[W] != diff[W-1]) begin
            y = diff[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end else begin
            y = diff[W-1:0];
        end
    end

    // leaky integrator: time constant 2^SH samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
        end else if (strobe && !freeze) begin
            acc_reg <= acc_reg + AW'(x) - AW'(ofs);
        end
    end

    property p_frozen;
        @(posedge clk) disable iff (!rst_n) freeze |=> $stable(acc_reg);
    endproperty
    a_frozen: assert property (p_frozen) else $error("offset moved while frozen");

    property p_tracks;
        @(posedge clk) disable iff (!rst_n) strobe && !freeze && (x != ofs) |=> !$stable(acc_reg);
    endproperty
    a_tracks: assert property (p_tracks) else $error("offset estimate not updated");
endmodule // cdpc_dc_block

//--- rtl/cdpc_codec_proc.sv
`timescale 1ns/1ns
`include "cdpc_consts.svh"
module cdpc_codec_proc #(
    parameter int SILENCE_COUNT = `CDPC_SILENCE_COUNT,
    parameter int PWRUP_CYCLES = (`CDPC_PWRUP_NS + `CDPC_CLK_PERIOD_NS - 1) / `CDPC_CLK_PERIOD_NS,
    parameter int HPF_SHIFT = `CDPC_HPF_SHIFT
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic FRAME_CLOCK,
    input wire cdpc_pkg::cdpc_stereo_t ADC_DECIMATED,
    input wire cdpc_pkg::cdpc_stereo_t SERIAL_AUDIO_IN,
    input wire logic RATIO_INVALID,
    output cdpc_pkg::cdpc_stereo_t SERIAL_AUDIO_OUT,
    output cdpc_pkg::cdpc_stereo_t DAC_WORDS,
    output logic ADC_FORMAT_SELECT,
    output cdpc_pkg::cdpc_dac_cfg_t DAC_CFG,
    output logic [1:0] EXTERNAL_MUTE_OUT_N
);
    localparam int W = `CDPC_WORD_W;
    localparam int PCW = $clog2(PWRUP_CYCLES + 1);
    localparam logic [W-1:0] DITHER_HALF = W'(1) << (W - 17);

    // ****************************************
    // control registers and APB slave
    // ****************************************
    logic [7:0] mode1_reg, dac_reg, mix_reg, vola_reg, volb_reg, adc_reg, mode2_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [7:0] idx, rd_mux, status;
    logic setup, wr_go, mapped;

    assign idx = PADDR[9:2];
    assign setup = PSEL && !PENABLE;
    assign wr_go = PSEL && PENABLE && pready_reg && PWRITE;
    assign mapped = (PADDR[11:10] == 2'h0) && (PADDR[1:0] == 2'h0)
                    && (idx >= `CDPC_IDX_MODE1) && (idx <= `CDPC_IDX_STAT);

    // read mux; the status word is read-only
    always_comb begin
        case (idx)
            `CDPC_IDX_MODE1: rd_mux = mode1_reg;
            `CDPC_IDX_DAC: rd_mux = dac_reg;
            `CDPC_IDX_MIX: rd_mux = mix_reg;
            `CDPC_IDX_VOLA: rd_mux = vola_reg;
            `CDPC_IDX_VOLB: rd_mux = volb_reg;
            `CDPC_IDX_ADC: rd_mux = adc_reg;
            `CDPC_IDX_MODE2: rd_mux = mode2_reg;
            `CDPC_IDX_STAT: rd_mux = status;
            default: rd_mux = 8'h00;
        endcase
    end

    // one wait-free access phase: answer is prepared during setup
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup) begin
                prdata_reg <= (mapped && !PWRITE) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            end
        end
    end

    // register writes land at the completing access edge only
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            mode1_reg <= `CDPC_RST_MODE1;
            dac_reg <= `CDPC_RST_DAC;
            mix_reg <= `CDPC_RST_MIX;
            vola_reg <= `CDPC_RST_VOL;
            volb_reg <= `CDPC_RST_VOL;
            adc_reg <= `CDPC_RST_ADC;
            mode2_reg <= `CDPC_RST_MODE2;
        end else if (wr_go && mapped) begin
            case (idx)
                `CDPC_IDX_MODE1: mode1_reg <= PWDATA[7:0]; // field stored even in loopback
                `CDPC_IDX_DAC: dac_reg <= PWDATA[7:0];
                `CDPC_IDX_MIX: mix_reg <= PWDATA[7:0];
                `CDPC_IDX_VOLA: vola_reg <= PWDATA[7:0];
                `CDPC_IDX_VOLB: volb_reg <= PWDATA[7:0];
                `CDPC_IDX_ADC: adc_reg <= PWDATA[7:0];
                `CDPC_IDX_MODE2: mode2_reg <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // frame clock sampling
    // ****************************************
    logic frame_meta_reg, frame_sync_reg, frame_prev_reg, strobe;

    // first flop feeds only the second; edge found after that
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            frame_meta_reg <= 1'b0;
            frame_sync_reg <= 1'b0;
            frame_prev_reg <= 1'b0;
        end else begin
            frame_meta_reg <= FRAME_CLOCK;
            frame_sync_reg <= frame_meta_reg;
            frame_prev_reg <= frame_sync_reg;
        end
    end
    assign strobe = frame_sync_reg && !frame_prev_reg;

    // ****************************************
    // power-up sequencing
    // ****************************************
    cdpc_pkg::cdpc_pwr_t pwr_reg;
    logic [PCW-1:0] pwr_cnt_reg;

    // mute stays on through the power-up wait; long count is a parameter
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            pwr_reg <= cdpc_pkg::PWR_DOWN;
            pwr_cnt_reg <= '0;
        end else if (mode2_reg[`CDPC_PDN]) begin
            pwr_reg <= cdpc_pkg::PWR_DOWN;
            pwr_cnt_reg <= '0;
        end else begin
            case (pwr_reg)
                cdpc_pkg::PWR_DOWN: pwr_reg <= cdpc_pkg::PWR_RAMP;
                cdpc_pkg::PWR_RAMP: begin
                    if (pwr_cnt_reg == PCW'(PWRUP_CYCLES - 1)) begin
                        pwr_reg <= cdpc_pkg::PWR_RUN;
                    end
                    pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
                end
                cdpc_pkg::PWR_RUN: pwr_reg <= cdpc_pkg::PWR_RUN;
                default: pwr_reg <= cdpc_pkg::PWR_DOWN;
            endcase
        end
    end

    // ****************************************
    // per-channel ADC and silence paths
    // ****************************************
    logic [15:0] lfsr_reg;
    logic [1:0][W-1:0] hpf_y, adc_word;
    logic [1:0] det, freeze, adc_mute;
    logic loop_eff, linked;

    assign loop_eff = mode2_reg[`CDPC_LOOP] && mode2_reg[`CDPC_CPEN];
    assign linked = mode2_reg[`CDPC_LINK];
    assign freeze = {adc_reg[`CDPC_HPFRZ_B], adc_reg[`CDPC_HPFRZ_A]};
    assign adc_mute = {adc_reg[`CDPC_ADCMUTE_B], adc_reg[`CDPC_ADCMUTE_A]};

    // noise source for dither, one step per frame
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            lfsr_reg <= 16'hACE1;
        end else if (strobe) begin
            lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_chan
        logic [W-1:0] dith_sum;

        cdpc_dc_block #(.W(W), .SH(HPF_SHIFT)) u_hpf (
            .clk(CLK_SYS),
            .rst_n(RESET_N),
            .strobe(strobe),
            .freeze(freeze[i]),
            .x(ADC_DECIMATED.ch[i]),
            .y(hpf_y[i])
        );

        // silence is judged on what the DAC really receives
        cdpc_silence_det #(.W(W), .LIMIT(SILENCE_COUNT)) u_det (
            .clk(CLK_SYS),
            .rst_n(RESET_N),
            .strobe(strobe),
            .sample(DAC_WORDS.ch[i]),
            .detected(det[i]),
            .count()
        );

        // half a 16-bit LSB; left off near positive full scale rather than wrapped
        assign dith_sum = hpf_y[i] + (lfsr_reg[i] ? DITHER_HALF : '0);
        always_comb begin
            if (adc_mute[i]) begin
                adc_word[i] = '0;
            end else if (adc_reg[`CDPC_DITHER] && !(dith_sum[W-1] && !hpf_y[i][W-1])) begin
                adc_word[i] = dith_sum; // format and clock mode play no part
            end else begin
                adc_word[i] = hpf_y[i];
            end
        end
    end

    // ****************************************
    // sample registers and loopback routing
    // ****************************************
    cdpc_pkg::cdpc_stereo_t sout_reg, dac_words_reg;

    // dac word updates one clock after the strobe that samples its input
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sout_reg <= '0;
            dac_words_reg <= '0;
        end else if (strobe) begin
            sout_reg.ch <= adc_word;
            dac_words_reg <= loop_eff ? cdpc_pkg::cdpc_stereo_t'(adc_word) : SERIAL_AUDIO_IN;
        end
    end

    // ****************************************
    // DAC configuration and mute outputs
    // ****************************************
    cdpc_pkg::cdpc_dac_cfg_t cfg_reg, cfg_next;
    cdpc_pkg::cdpc_speed_t speed;
    logic [1:0] silence_next, mute_n_reg, mute_n_next;
    logic adc_fmt_reg;

    assign speed = cdpc_pkg::cdpc_speed_t'({mode1_reg[`CDPC_SPEED_HI], mode1_reg[`CDPC_SPEED_LO]});

    // linked: both must be silent to mute, either live sample releases both
    always_comb begin
        if (!dac_reg[`CDPC_AUTOSIL]) begin
            silence_next = 2'b00;
        end else if (linked) begin
            silence_next = {2{det[0] && det[1]}};
        end else begin
            silence_next = det;
        end
    end

    always_comb begin
        cfg_next = cfg_reg;
        if (!loop_eff) begin
            cfg_next.dac_format = mode1_reg[`CDPC_DACFMT_MSB:0];
        end
        cfg_next.rolloff_slow = dac_reg[`CDPC_ROLLOFF];
        cfg_next.deemphasis = (speed == cdpc_pkg::SPEED_SINGLE)
                              ? dac_reg[`CDPC_DEEMPH_MSB:`CDPC_DEEMPH_LSB] : 2'h0;
        case (speed)
            cdpc_pkg::SPEED_SINGLE: cfg_next.oversample = `CDPC_OSR_SINGLE;
            cdpc_pkg::SPEED_DOUBLE: cfg_next.oversample = `CDPC_OSR_DOUBLE;
            default: cfg_next.oversample = `CDPC_OSR_QUAD;
        endcase
        cfg_next.soft_ramp = mix_reg[`CDPC_SOFT];
        cfg_next.zero_crossing_gate = mix_reg[`CDPC_ZEROX];
        cfg_next.silence_req = silence_next | {volb_reg[`CDPC_VOLMUTE], vola_reg[`CDPC_VOLMUTE]};
        // any reason to be quiet pulls the pin low
        mute_n_next = ~(cfg_next.silence_req
                        | {2{pwr_reg != cdpc_pkg::PWR_RUN || RATIO_INVALID || mode2_reg[`CDPC_PDN]}});
    end

    // reset value asserts the mute pins from the first moment
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_reg <= '0;
            mute_n_reg <= 2'b00;
            adc_fmt_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            mute_n_reg <= mute_n_next;
            adc_fmt_reg <= adc_reg[`CDPC_ADCFMT];
        end
    end

    assign status = {pwr_reg, cfg_reg.silence_req, mute_n_reg, loop_eff, RATIO_INVALID};
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign SERIAL_AUDIO_OUT = sout_reg;
    assign DAC_WORDS = dac_words_reg;
    assign DAC_CFG = cfg_reg;
    assign ADC_FORMAT_SELECT = adc_fmt_reg;
    assign EXTERNAL_MUTE_OUT_N = mute_n_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    sequence s_loop_frame;
        loop_eff && strobe;
    endsequence
    property p_loop_route;
        s_loop_frame |=> DAC_WORDS == SERIAL_AUDIO_OUT;
    endproperty
    a_loop_route: assert property (p_loop_route) else $error("loopback did not route ADC word");

    property p_fmt_frozen;
        loop_eff ##1 loop_eff |-> $stable(DAC_CFG.dac_format);
    endproperty
    a_fmt_frozen: assert property (p_fmt_frozen) else $error("DAC format changed in loopback");

    sequence s_loop_release;
        $fell(loop_eff) ##1 1'b1;
    endsequence
    property p_fmt_release;
        s_loop_release |-> DAC_CFG.dac_format == mode1_reg[`CDPC_DACFMT_MSB:0];
    endproperty
    a_fmt_release: assert property (p_fmt_release) else $error("stored DAC format not applied");

    property p_adc_fmt;
        ##1 ADC_FORMAT_SELECT == $past(adc_reg[`CDPC_ADCFMT]);
    endproperty
    a_adc_fmt: assert property (p_adc_fmt) else $error("ADC format output wrong");

    property p_no_dither;
        strobe && !adc_reg[`CDPC_DITHER] && !adc_mute[0] |=> SERIAL_AUDIO_OUT.ch[0] == $past(hpf_y[0]);
    endproperty
    a_no_dither: assert property (p_no_dither) else $error("word altered without dither");

    property p_silence_pin;
        silence_next[0] |=> !EXTERNAL_MUTE_OUT_N[0] && DAC_CFG.silence_req[0];
    endproperty
    a_silence_pin: assert property (p_silence_pin) else $error("silence did not pull mute pin low");

    property p_linked;
        linked && DAC_CFG.silence_req == 2'b01 |-> vola_reg[`CDPC_VOLMUTE] || $past(!linked);
    endproperty
    a_linked: assert property (p_linked) else $error("linked channels muted apart");

    sequence s_power_down;
        mode2_reg[`CDPC_PDN] || RATIO_INVALID;
    endsequence
    property p_down_mute;
        s_power_down |=> EXTERNAL_MUTE_OUT_N == 2'b00;
    endproperty
    a_down_mute: assert property (p_down_mute) else $error("mute pins released while down");

    property p_deemph;
        speed != cdpc_pkg::SPEED_SINGLE |=> DAC_CFG.deemphasis == 2'h0;
    endproperty
    a_deemph: assert property (p_deemph) else $error("de-emphasis outside single speed");

    property p_osr;
        speed == cdpc_pkg::SPEED_DOUBLE |=> DAC_CFG.oversample == `CDPC_OSR_DOUBLE;
    endproperty
    a_osr: assert property (p_osr) else $error("wrong oversampling ratio");
endmodule // cdpc_codec_proc

//--- dv/cdpc_host_model.sv
`timescale 1ns/1ns
// ****************************************
// serial host stand-in
// ****************************************
module cdpc_host_model (
    input wire logic run,
    input wire cdpc_pkg::cdpc_stereo_t word,
    output logic frame_clock,
    output cdpc_pkg::cdpc_stereo_t audio
);
    // frame clock stands low outside runs; a new pair starts each frame
    initial begin
        frame_clock = 1'b0;
        audio = '0;
        forever begin
            #40;
            frame_clock = run ? ~frame_clock : 1'b0;
            if (frame_clock) audio = word;
        end
    end
endmodule // cdpc_host_model

//--- dv/codec_digital_processing_ctrl_tb.sv
`timescale 1ns/1ns
module codec_digital_processing_ctrl_tb;
    // ****************************************
    // signals and instances
    // ****************************************
    logic CLK_SYS = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic RATIO_INVALID = 1'b0, run = 1'b0, PREADY, PSLVERR, FRAME_CLOCK, err, ADC_FORMAT_SELECT;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [1:0] EXTERNAL_MUTE_OUT_N;
    cdpc_pkg::cdpc_stereo_t ADC_DECIMATED = '0, word = '0, SERIAL_AUDIO_IN, SERIAL_AUDIO_OUT, DAC_WORDS;
    cdpc_pkg::cdpc_dac_cfg_t DAC_CFG;
    int bad_count = 0, samples_checked = 0;
    always #5 CLK_SYS = ~CLK_SYS;
    // short counts keep the silence and power-up waits small
    cdpc_codec_proc #(.SILENCE_COUNT(8), .PWRUP_CYCLES(4)) DUT (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_CLOCK(FRAME_CLOCK), .ADC_DECIMATED(ADC_DECIMATED),
        .SERIAL_AUDIO_IN(SERIAL_AUDIO_IN), .RATIO_INVALID(RATIO_INVALID), .SERIAL_AUDIO_OUT(SERIAL_AUDIO_OUT),
        .DAC_WORDS(DAC_WORDS), .ADC_FORMAT_SELECT(ADC_FORMAT_SELECT), .DAC_CFG(DAC_CFG),
        .EXTERNAL_MUTE_OUT_N(EXTERNAL_MUTE_OUT_N));
    cdpc_host_model host (.run(run), .word(word), .frame_clock(FRAME_CLOCK), .audio(SERIAL_AUDIO_IN));
    // ****************************************
    // tasks
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            results();
        end
        @(posedge CLK_SYS);
    endtask
    // frames are 8 clocks; the extra edges cover the frame clock synchroniser
    task automatic frames(input int k);
        repeat (k * 8 + 4) @(posedge CLK_SYS);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge CLK_SYS);
        check(EXTERNAL_MUTE_OUT_N, 2'b00);
        RESET_N <= 1'b1;
        apb(0, 12'h008, 0);
        check(rd, 32'h80);
        apb(0, 12'h040, 0);
        check(err, 1'b1);
        apb(1, 12'h01C, 32'h02);
        word <= {24'h123456, 24'h123456};
        run <= 1'b1;
        frames(4);
        check(EXTERNAL_MUTE_OUT_N, 2'b11);
        $display("test reset and power-up done");
        word <= '0;
        frames(12);
        check(EXTERNAL_MUTE_OUT_N, 2'b00);
        check(DAC_CFG.silence_req, 2'b11);
        check({DAC_CFG.soft_ramp, DAC_CFG.zero_crossing_gate}, 2'b10);
        word <= {24'hFFFFFF, 24'h000100};
        frames(2);
        check(EXTERNAL_MUTE_OUT_N, 2'b01);
        // linked: the live channel A keeps the silent channel B unmuted too
        apb(1, 12'h01C, 32'h0A);
        repeat (2) @(posedge CLK_SYS);
        check(EXTERNAL_MUTE_OUT_N, 2'b11);
        $display("test auto silence done");
        // freeze with a zero offset estimate, so ADC words pass unchanged
        apb(1, 12'h018, 32'h13);
        ADC_DECIMATED <= {24'h300000, 24'h200000};
        apb(1, 12'h01C, 32'h12);
        apb(1, 12'h004, 32'h05);
        frames(3);
        check(SERIAL_AUDIO_OUT, {24'h300000, 24'h200000});
        check(DAC_WORDS, {24'h300000, 24'h200000});
        check(DAC_CFG.dac_format, 3'h0);
        check(ADC_FORMAT_SELECT, 1'b1);
        apb(1, 12'h01C, 32'h02);
        frames(2);
        check(DAC_CFG.dac_format, 3'h5);
        check(DAC_WORDS, {24'hFFFFFF, 24'h000100});
        apb(1, 12'h018, 32'h23);
        frames(2);
        check({SERIAL_AUDIO_OUT.ch[1][23:8], SERIAL_AUDIO_OUT.ch[0][23:8]}, 32'h30002000);
        $display("test loopback and dither done");
        apb(1, 12'h008, 32'hD0);
        for (int i = 0; i < 3; i++) begin
            apb(1, 12'h004, 32'(i << 6));
            frames(1);
            check(DAC_CFG.oversample, 8'h80 >> i);
            check(DAC_CFG.deemphasis, (i == 0) ? 2'h1 : 2'h0);
            check(DAC_CFG.rolloff_slow, 1'b1);
        end
        // power-down mutes at once; the ramp after it keeps the mute on
        apb(1, 12'h01C, 32'h03);
        repeat (2) @(posedge CLK_SYS);
        check(EXTERNAL_MUTE_OUT_N, 2'b00);
        apb(1, 12'h01C, 32'h02);
        repeat (2) @(posedge CLK_SYS);
        check(EXTERNAL_MUTE_OUT_N, 2'b00);
        repeat (6) @(posedge CLK_SYS);
        check(EXTERNAL_MUTE_OUT_N, 2'b01);
        RATIO_INVALID <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        check(EXTERNAL_MUTE_OUT_N, 2'b00);
        $display("test speed and ratio done");
        // reset in mid-run brings back mute and the reset register values
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        check(EXTERNAL_MUTE_OUT_N, 2'b00);
        RESET_N <= 1'b1;
        apb(0, 12'h008, 0);
        check(rd, 32'h80);
        $display("test mid-run reset done");
        results();
    end
endmodule // codec_digital_processing_ctrl_tb
